//--- bcd_pkg.sv
// Constants shared by the commutation and direction logic.
`default_nettype none
package bcd_pkg;
    // System clock.
    localparam int unsigned CLK_HZ = 50_000_000;
    // PWM oscillator and its ramp.
    localparam int unsigned PWM_OSC_HZ = 10_500;
    localparam int unsigned RAMP_W = 8;
    localparam int unsigned RAMP_STEPS = 256;
    localparam int unsigned RAMP_STEP_CYCLES_RAW =
        CLK_HZ / (PWM_OSC_HZ * RAMP_STEPS);
    localparam int unsigned RAMP_STEP_CYCLES =
        (RAMP_STEP_CYCLES_RAW < 1) ? 1 : RAMP_STEP_CYCLES_RAW;
    localparam int unsigned STEP_W = 8;
    localparam logic [RAMP_W-1:0] RAMP_TOP = 8'hFF;
    // Speed output pulse width.
    localparam int unsigned TACH_PULSE_MS = 150;
    localparam int unsigned TACH_PULSE_CYCLES =
        TACH_PULSE_MS * (CLK_HZ / 1000);
    localparam int unsigned TACH_W = 24;
    // Reset values.
    localparam logic [2:0] HALL_RST = 3'h0;
    localparam logic [2:0] DRIVE_OFF = 3'h0;
    localparam logic DIR_RST = 1'b0;
    // Phase bit positions inside a three-phase vector.
    localparam int unsigned PH_A = 0;
    localparam int unsigned PH_B = 1;
    localparam int unsigned PH_C = 2;
endpackage : bcd_pkg
`default_nettype wire

//--- bcd_commutator.sv
// Commutation, direction dead time, PWM chopping and speed pulse logic.
`timescale 1ns/1ns
`default_nettype none
module bcd_commutator #(
    parameter int unsigned TACH_CYCLES = bcd_pkg::TACH_PULSE_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Rotor position sensors, bit 2 is sensor A.
    input wire logic [2:0] hall,
    // Control inputs.
    input wire logic direction,
    input wire logic drive_enable,
    input wire logic sensor_reference_ok,
    input wire logic [bcd_pkg::RAMP_W-1:0] current_error,
    // Phase drivers, bit 0 phase A, bit 1 phase B, bit 2 phase C.
    output logic [2:0] phase_source,
    output logic [2:0] phase_sink,
    // Speed output.
    output logic speed_pulse
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding of the sensor code and direction.

    // Returns {source, sink}; direction low swaps source and sink.
    function automatic logic [5:0] commutate(input logic [2:0] code,
                                             input logic dir);
        logic [2:0] src;
        logic [2:0] snk;
        src = bcd_pkg::DRIVE_OFF;
        snk = bcd_pkg::DRIVE_OFF;
        // Codes 000 and 111 cannot come from healthy sensors.
        case (code)
            3'h1: begin
                src = 3'h4;
                snk = 3'h2;
            end
            3'h3: begin
                src = 3'h4;
                snk = 3'h1;
            end
            3'h2: begin
                src = 3'h2;
                snk = 3'h1;
            end
            3'h6: begin
                src = 3'h2;
                snk = 3'h4;
            end
            3'h4: begin
                src = 3'h1;
                snk = 3'h4;
            end
            3'h5: begin
                src = 3'h1;
                snk = 3'h2;
            end
            default: begin
                src = bcd_pkg::DRIVE_OFF;
                snk = bcd_pkg::DRIVE_OFF;
            end
        endcase
        if (dir) begin
            commutate = {src, snk};
        end else begin
            commutate = {snk, src};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State.

    logic active;
    logic [bcd_pkg::STEP_W-1:0] step_q;
    logic [bcd_pkg::STEP_W-1:0] step_d;
    logic [bcd_pkg::RAMP_W-1:0] ramp_q;
    logic [bcd_pkg::RAMP_W-1:0] ramp_d;
    logic dir_latch_q;
    logic dir_stage1_q;
    logic dir_stage2_q;
    logic [2:0] hall_q;
    logic [bcd_pkg::TACH_W-1:0] tach_q;
    logic [bcd_pkg::TACH_W-1:0] tach_d;
    logic [2:0] source_d;
    logic [2:0] sink_d;
    logic speed_d;

    ////////////////////////////////////////////////////////////////////////
    // PWM oscillator: a ramp stepped by a divider enable.

    wire logic step_wrap;
    wire logic ramp_step;
    wire logic osc_tick;
    wire logic pwm_on;

    // Nothing runs until the sensor supply is in regulation.
    assign active = sensor_reference_ok;
    assign step_wrap =
        (step_q == bcd_pkg::STEP_W'(bcd_pkg::RAMP_STEP_CYCLES - 1));
    assign step_d = step_wrap ? '0 : step_q + 1'b1;
    assign ramp_step = step_wrap;
    assign ramp_d = ramp_q + 1'b1;
    // One oscillator period ends each time the ramp wraps.
    assign osc_tick = ramp_step && (ramp_q == bcd_pkg::RAMP_TOP);
    // Upper drivers conduct while the error stands above the ramp.
    assign pwm_on = (current_error > ramp_q);

    // The ramp restarts from zero whenever the logic leaves idle, so the
    // dead time after power-up is counted from a known phase.
    always_ff @(posedge clock) begin
        if (rst || !active) begin
            step_q <= '0;
            ramp_q <= '0;
        end else begin
            step_q <= step_d;
            if (ramp_step) begin
                ramp_q <= ramp_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Direction latch and two-stage shift register.

    wire logic dir_settled;

    // Any disagreement along the chain means a reversal is under way.
    assign dir_settled = (direction == dir_latch_q) &&
                         (dir_latch_q == dir_stage1_q) &&
                         (dir_stage1_q == dir_stage2_q);

    // A reversal must pass two oscillator ticks before the decoder sees it,
    // which keeps both drivers of a leg from conducting across the change.
    always_ff @(posedge clock) begin
        if (rst || !active) begin
            dir_latch_q <= bcd_pkg::DIR_RST;
            dir_stage1_q <= bcd_pkg::DIR_RST;
            dir_stage2_q <= bcd_pkg::DIR_RST;
        end else begin
            dir_latch_q <= direction;
            if (osc_tick) begin
                dir_stage1_q <= dir_latch_q;
                dir_stage2_q <= dir_stage1_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase drive.

    wire logic [5:0] decoded;
    wire logic drive_ok;

    // The decoder sees only the delayed direction.
    assign decoded = commutate(hall, dir_stage2_q);
    // Enable, supply and a settled direction must all agree before any
    // leg conducts.
    assign drive_ok = active && drive_enable && dir_settled;
    // Only the upper drivers are chopped; the lower driver of the sinking
    // phase stays on through the whole period.
    assign source_d = (drive_ok && pwm_on) ? decoded[5:3]
                                           : bcd_pkg::DRIVE_OFF;
    assign sink_d = drive_ok ? decoded[2:0] : bcd_pkg::DRIVE_OFF;

    // Registered so the pins never glitch while the decoder settles.
    always_ff @(posedge clock) begin
        if (rst) begin
            phase_source <= bcd_pkg::DRIVE_OFF;
            phase_sink <= bcd_pkg::DRIVE_OFF;
        end else begin
            phase_source <= source_d;
            phase_sink <= sink_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Speed output: a fixed pulse restarted by every sensor edge.

    wire logic hall_edge;
    wire logic tach_busy;
    wire logic [bcd_pkg::TACH_W-1:0] tach_load;
    wire logic [bcd_pkg::TACH_W-1:0] tach_next;

    // Each edge restarts the full width, so a fast rotor keeps the pin high.
    assign hall_edge = (hall != hall_q);
    assign tach_load = bcd_pkg::TACH_W'(TACH_CYCLES);
    assign tach_busy = (tach_q != '0);
    assign tach_next = tach_busy ? tach_q - 1'b1 : tach_q;
    assign tach_d = hall_edge ? tach_load : tach_next;
    assign speed_d = (tach_d != '0);

    // The sensor sample follows the pins even while reset or the supply
    // holds the logic idle, so the first active edge never sees a false
    // sensor edge and no edge taken while idle is counted afterwards.
    always_ff @(posedge clock) begin
        if (rst || !active) begin
            hall_q <= hall;
            tach_q <= '0;
            speed_pulse <= 1'b0;
        end else begin
            hall_q <= hall;
            tach_q <= tach_d;
            speed_pulse <= speed_d;
        end
    end

endmodule // bcd_commutator
`default_nettype wire

//--- bcd_commutator_assertions.sv
// Port assertions for the commutator.
`timescale 1ns/1ns
`default_nettype none
module bcd_commutator_assertions #(parameter int unsigned TACH_CYCLES = 20) (
    // Clock, reset and inputs.
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] hall,
    input wire logic direction,
    input wire logic drive_enable,
    input wire logic sensor_reference_ok,
    input wire logic [bcd_pkg::RAMP_W-1:0] current_error,
    // Outputs.
    input wire logic [2:0] phase_source,
    input wire logic [2:0] phase_sink,
    input wire logic speed_pulse
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [2:0] hall_q;
    logic [31:0] cnt_q;
    wire logic off = (phase_source | phase_sink) == 3'h0;
    always_ff @(posedge clock) hall_q <= hall;
    // Cycles since the last sensor edge, up to one past the pulse.
    always_ff @(posedge clock) begin
        if (rst || !sensor_reference_ok) cnt_q <= '0;
        else if (hall != hall_q) cnt_q <= 32'h1;
        else if (cnt_q != 0 && cnt_q <= TACH_CYCLES) cnt_q <= cnt_q + 1;
        else cnt_q <= '0;
    end
    a_no_shoot: assert property (!(|(phase_source & phase_sink)))
        else $error("shoot through");
    a_bad_code: assert property (hall inside {3'h0, 3'h7} |=> off)
        else $error("illegal code drives");
    a_enable_off: assert property (!drive_enable |=> off)
        else $error("drives while disabled");
    a_supply_off: assert property (!sensor_reference_ok [*2] |=> off)
        else $error("drives without supply");
    a_dir_dead: assert property ($changed(direction) |=> ##1 off [*8])
        else $error("no dead time");
    a_chop_off: assert property (
        current_error == '0 |=> phase_source == 3'h0) else $error("chop");
    a_tach_hold: assert property (
        cnt_q inside {[1:TACH_CYCLES]} |-> speed_pulse) else $error("short");
    a_tach_end: assert property (
        cnt_q == TACH_CYCLES + 1 |-> !speed_pulse) else $error("long");
endmodule // bcd_commutator_assertions
bind bcd_commutator bcd_commutator_assertions #(.TACH_CYCLES(TACH_CYCLES))
    bcd_commutator_assertions_i (.clock(clock), .rst(rst), .hall(hall),
    .direction(direction), .drive_enable(drive_enable),
    .sensor_reference_ok(sensor_reference_ok),
    .current_error(current_error), .phase_source(phase_source),
    .phase_sink(phase_sink), .speed_pulse(speed_pulse));
`default_nettype wire

//--- bcd_hall_model.sv
// Rotor sensor model: 60-degree sensors with the middle one inverted.
`timescale 1ns/1ns
`default_nettype none
module bcd_hall_model (
    // Clock and rotation control.
    input wire logic clock,
    input wire logic step,
    input wire logic broken,
    // Sensor lines; an open harness reads high through the pull-ups.
    output logic [2:0] hall
);
    logic [2:0] seq [6] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h6, 3'h4};
    int pos = 0;
    always @(posedge clock) if (step) pos <= (pos + 1) % 6;
    assign hall = broken ? 3'h7 : seq[pos] ^ 3'h2;
endmodule // bcd_hall_model
`default_nettype wire

//--- tb_bcd_commutator.sv
// Self-checking bench for the commutator.
`timescale 1ns/1ns
`default_nettype none
module tb_bcd_commutator;
    localparam int TP = 20;
    localparam int PER = 4608;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic dir = 1'b0;
    logic en = 1'b1;
    logic ok = 1'b1;
    logic step = 1'b0;
    logic broken = 1'b0;
    logic [7:0] err = 8'hFF;
    logic [2:0] hall, src, snk;
    logic spd;
    int bad_count = 0;
    int checks_done = 0;
    int seed = 32'h74c6_afa3;
    int ramp_cyc = 0;
    int ramp_seen = 0;
    logic [2:0] src1 [8] = '{3'h0, 3'h4, 3'h2, 3'h4, 3'h1, 3'h1, 3'h2, 3'h0};
    logic [2:0] snk1 [8] = '{3'h0, 3'h2, 3'h1, 3'h1, 3'h4, 3'h2, 3'h4, 3'h0};
    always #10 clock = ~clock;
    // Ramp model: one step per divider period, cleared while idle.
    always @(posedge clock) begin
        ramp_seen <= (ramp_cyc / bcd_pkg::RAMP_STEP_CYCLES)
            % bcd_pkg::RAMP_STEPS;
        if (rst || !ok) begin
            ramp_cyc <= 0;
        end else begin
            ramp_cyc <= ramp_cyc + 1;
        end
    end
    bcd_hall_model bcd_hall_model_i (.clock(clock), .step(step),
        .broken(broken), .hall(hall));
    bcd_commutator #(.TACH_CYCLES(TP)) bcd_commutator_i (.clock(clock),
        .rst(rst), .hall(hall), .direction(dir), .drive_enable(en),
        .sensor_reference_ok(ok), .current_error(err), .phase_source(src),
        .phase_sink(snk), .speed_pulse(spd));
    task automatic tick(int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic cmp(string what, logic [2:0] exp, logic [2:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_speed(logic exp);
        checks_done++;
        if (spd !== exp) begin
            bad_count++;
            $display("BAD speed expected %h seen %h", exp, spd);
        end
    endtask
    task automatic phases(logic drive);
        logic [2:0] es;
        logic [2:0] ek;
        @(negedge clock);
        es = drive ? (dir ? src1[hall] : snk1[hall]) : 3'h0;
        ek = drive ? (dir ? snk1[hall] : src1[hall]) : 3'h0;
        // Upper drivers conduct only while the error is above the ramp.
        if (err <= ramp_seen) begin
            es = 3'h0;
        end
        cmp("sink", ek, snk);
        cmp("source", es, src);
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        tick(40000);
        bad_count++;
        report_and_stop();
    end
    initial begin
        tick(12);
        rst <= 1'b0;
        for (int d = 0; d < 2; d++) begin
            for (int i = 0; i < 7; i++) begin
                tick(1);
                step <= 1'b1;
                err <= (i == 3) ? 8'h00 : 8'($random(seed));
                tick(1);
                step <= 1'b0;
                tick(2);
                phases(1'b1);
                cmp_speed(1'b1);
                tick(TP - 2);
                @(negedge clock);
                cmp_speed(1'b1);
                tick(1);
                @(negedge clock);
                cmp_speed(1'b0);
            end
            tick(1);
            dir <= ~dir;
            tick(PER - 10);
            phases(1'b0);
            tick(PER + 20);
            phases(1'b1);
        end
        tick(1);
        en <= 1'b0;
        tick(2);
        phases(1'b0);
        tick(1);
        en <= 1'b1;
        ok <= 1'b0;
        tick(3);
        phases(1'b0);
        tick(1);
        ok <= 1'b1;
        tick(1);
        broken <= 1'b1;
        tick(2);
        phases(1'b0);
        tick(1);
        broken <= 1'b0;
        tick(2 * PER + 20);
        phases(1'b1);
        report_and_stop();
    end
endmodule // tb_bcd_commutator
`default_nettype wire
